// ---- dv/controller_side_model.sv ----
// controller-side sideband model: request addresses, lane A address, sleep levels
// assumes the bench calls drive from its main sequence, clocked by aclk
`timescale 1ns/1ps
module controller_side_model (
  input wire logic aclk,
  output logic [5:0] serial_req_address,
  output logic [4:0] memory_req_address,
  output logic [4:0] data_lane_a_address,
  output logic auto_skip_sample,
  output logic light_sleep_state,
  output logic deep_powerdown_state
);
  initial begin
    serial_req_address = 6'h00;
    memory_req_address = 5'h00;
    data_lane_a_address = 5'h00;
    auto_skip_sample = 1'b0;
    light_sleep_state = 1'b0;
    deep_powerdown_state = 1'b0;
  end

  // levels move just after an edge so the device never sees them change on one
  task automatic drive(input logic [5:0] sa, input logic [4:0] ma, input logic [4:0] la,
                       input logic sk, input logic ls, input logic dp);
    @(posedge aclk);
    serial_req_address <= sa;
    memory_req_address <= ma;
    data_lane_a_address <= la;
    auto_skip_sample <= sk;
    light_sleep_state <= ls;
    deep_powerdown_state <= dp;
  endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the control register bank over AXI4-Lite
// assumes the cfg header and package are compiled first
`timescale 1ns/1ps
`include "memory_control_register_map_cfg.svh"
module testbench;
  localparam logic [7:0] EV = `IDX_EVENT_CONTROL;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] serial_req_address;
  logic [4:0] memory_req_address, data_lane_a_address;
  logic auto_skip_sample, light_sleep_state, deep_powerdown_state;
  logic serial_address_match, memory_address_match, exit_address_ok, self_refresh_active;
  logic low_power_self_refresh, framing_select, effective_skip;
  logic [2:0] read_delay_base, read_delay_extra;
  logic [3:0] framing_offset, next_bank_to_renew;
  logic [13:0] cycle_time_setting;
  logic [8:0] next_row_to_renew;
  int n_mismatch, n_checks;
  logic [7:0] ix [10] = '{8'h40, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h4A, 8'h4C};
  logic [31:0] vv [10] = '{32'h1F, 32'h1FF, 32'h1FF, 32'h1FF, 32'h7FF, 32'h1FFF, 32'h1FFF,
                           32'h7F, 32'h7, 32'h3FFF};

  memory_control_register_map memory_control_register_map_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_req_address, .memory_req_address,
    .data_lane_a_address, .auto_skip_sample, .light_sleep_state, .deep_powerdown_state,
    .serial_address_match, .memory_address_match, .exit_address_ok, .self_refresh_active,
    .low_power_self_refresh, .framing_select, .effective_skip, .read_delay_base,
    .read_delay_extra, .framing_offset, .cycle_time_setting, .next_bank_to_renew,
    .next_row_to_renew
  );
  controller_side_model controller_side_model_inst (
    .aclk, .serial_req_address, .memory_req_address, .data_lane_a_address,
    .auto_skip_sample, .light_sleep_state, .deep_powerdown_state
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, exp);
    chk(s_axi_rresp, er);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h42, 32'h0);
    rd(8'h23, 32'h0, 32'hFFFF_0000);
    rd(8'h24, 32'h0, 32'hFFFE_0000);
    wr(8'h4D, 32'h0);
    // field-wide values only: reserved bits stay zero
    for (int k = 0; k < 10; k++) wr(ix[k], vv[k]);
    for (int k = 0; k < 10; k++) rd(ix[k], vv[k]);
    wr(8'h49, 32'hF);
    rd(8'h49, 32'hF);
    chk({read_delay_base, read_delay_extra, framing_offset, framing_select}, 11'h7FF);
    chk(cycle_time_setting, 14'h3FFF);
    wr(8'h48, 32'h5A);
    wr(8'h45, 32'h2A5);
    rd(8'h45, 32'h2A5);
    chk({read_delay_base, framing_select}, 4'hA);
    // serial addr 2A, exit select, light and low-power refresh on
    wr(8'h21, 32'h56A);
    rd(8'h21, 32'h56A);
    controller_side_model_inst.drive(6'h2A, 5'h1F, 5'h05, 1'b1, 1'b0, 1'b1);
    #1;
    chk({serial_address_match, memory_address_match, exit_address_ok,
         self_refresh_active, low_power_self_refresh}, 5'b11001);
    controller_side_model_inst.drive(6'h2B, 5'h1E, 5'h1F, 1'b1, 1'b1, 1'b0);
    #1;
    chk({serial_address_match, memory_address_match, exit_address_ok,
         self_refresh_active}, 4'b0011);
    wr(8'h21, 32'h200);
    controller_side_model_inst.drive(6'h00, 5'h1E, 5'h05, 1'b1, 1'b1, 1'b1);
    #1;
    chk({serial_address_match, exit_address_ok, self_refresh_active,
         low_power_self_refresh}, 4'b1110);
    wr(8'h41, 32'hE);
    wr(8'h42, 32'h5);
    wr(EV, 32'h20);
    rd(8'h41, 32'hF);
    wr(EV, 32'h20);
    rd(8'h41, 32'h0);
    rd(8'h42, 32'h6);
    // auto renew at the last bank steps the row only when memory_req_address matches the device address
    wr(8'h41, 32'hF);
    chk(next_bank_to_renew, 4'hF);
    wr(EV, 32'h10);
    rd(8'h42, 32'h6);
    controller_side_model_inst.drive(6'h00, 5'h1F, 5'h05, 1'b1, 1'b1, 1'b1);
    wr(EV, 32'h10);
    chk(next_row_to_renew, 9'h7);
    wr(EV, 32'h01);
    rd(8'h4B, 32'h1);
    chk(effective_skip, 1'b1);
    controller_side_model_inst.drive(6'h00, 5'h1F, 5'h05, 1'b0, 1'b1, 1'b1);
    rd(8'h4B, 32'h1);
    wr(EV, 32'h01);
    rd(8'h4B, 32'h0);
    chk(effective_skip, 1'b0);
    wr(8'h4B, 32'h7);
    rd(8'h4B, 32'h6);
    chk(effective_skip, 1'b1);
    wr(EV, 32'h08);
    // after serial reset: test_b written and read back, then cleared and kept registers checked
    wr(8'h4D, 32'h0);
    rd(8'h4D, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h42, 32'h0);
    rd(8'h4B, 32'h0);
    rd(8'h4C, 32'h3FFF);
    controller_side_model_inst.drive(6'h00, 5'h1F, 5'h05, 1'b1, 1'b1, 1'b1);
    wr(EV, 32'h01);
    wr(8'h42, 32'h33);
    wr(EV, 32'h02);
    wr(EV, 32'h04);
    rd(8'h42, 32'h0);
    rd(8'h4B, 32'h1);
    rd(EV, 32'h0);
    wr(8'h50, 32'h0, 2'h2);
    rd(8'h50, 32'h0, 32'hFFFF_FFFF, 2'h2);
    tally_and_finish();
  end
endmodule

// ---- rtl/memory_control_register_map.sv ----
// control and configuration register bank of a multi-bank memory device
// assumes an AXI4-Lite master on aclk; refresh events arrive as event_control writes, sleep states as same-clock levels
`timescale 1ns/1ps
`include "memory_control_register_map_cfg.svh"

module memory_control_register_map
  import memory_control_register_map_pkg::*;
#(
  parameter int ADDR_W = 12,
  // identity fields: arbitrary neutral values
  parameter logic [2:0] RENEW_BANK_BITS = 3'h4,
  parameter logic DOUBLED_BANK = 1'b1,
  parameter logic [5:0] MAKER_REVISION = 6'h01,
  parameter logic [5:0] PROTOCOL_REVISION = 6'h01,
  parameter logic NINE_BIT_WIDTH = 1'b0,
  parameter logic [2:0] DEVICE_CATEGORY = 3'h0,
  parameter logic SPLIT_CORE = 1'b0,
  parameter logic [5:0] CORE_LAYOUT = 6'h01,
  parameter logic [5:0] MASK_STEPPING = 6'h01
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] serial_req_address,
  input wire logic [4:0] memory_req_address,
  input wire logic [4:0] data_lane_a_address,
  input wire logic auto_skip_sample,
  input wire logic light_sleep_state,
  input wire logic deep_powerdown_state,
  output logic serial_address_match,
  output logic memory_address_match,
  output logic exit_address_ok,
  output logic self_refresh_active,
  output logic low_power_self_refresh,
  output logic framing_select,
  output logic effective_skip,
  output logic [2:0] read_delay_base,
  output logic [2:0] read_delay_extra,
  output logic [3:0] framing_offset,
  output logic [13:0] cycle_time_setting,
  output logic [3:0] next_bank_to_renew,
  output logic [8:0] next_row_to_renew
);

  // word index needs address bits 9:2
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must be 10..32");
  end

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[9:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  logic [13:0] startup_control_q;
  logic [15:0] test_a_q, test_b_q, test_c_q, test_d_q;
  logic [4:0] memory_device_address_q;
  logic [3:0] next_bank_q;
  logic [8:0] next_row_q;
  logic [8:0] drive_a_q, drive_b_q;
  logic [10:0] light_exit_q;
  logic [12:0] deep_phase_a_q, deep_total_q;
  logic [6:0] read_timing_q;
  logic [3:0] framing_q;
  logic [2:0] delay_extra_q;
  logic auto_skip_q, man_sel_q, man_val_q;
  logic [13:0] cycle_q;
  reset_seq_t rst_seq_q;

  // write channel
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_held_q, w_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic wr_hit;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = word_index(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read decode shared by both channels; unused read-only bits give zero
  function automatic logic [31:0] reg_value(input logic [7:0] idx);
    unique case (idx)
      `IDX_STARTUP_CONTROL: reg_value = {18'h0, startup_control_q};
      `IDX_TEST_SCRATCH_A: reg_value = {16'h0, test_a_q};
      `IDX_CORE_CONFIG_A: reg_value = {16'h0, PROTOCOL_REVISION, MAKER_REVISION,
                                       DOUBLED_BANK, RENEW_BANK_BITS};
      `IDX_CORE_CONFIG_B: reg_value = {15'h0, MASK_STEPPING, CORE_LAYOUT, SPLIT_CORE,
                                       DEVICE_CATEGORY, NINE_BIT_WIDTH};
      `IDX_MEMORY_DEVICE_ADDRESS: reg_value = {27'h0, memory_device_address_q};
      `IDX_NEXT_BANK: reg_value = {28'h0, next_bank_q};
      `IDX_NEXT_ROW: reg_value = {23'h0, next_row_q};
      `IDX_DRIVE_CURRENT_A: reg_value = {23'h0, drive_a_q};
      `IDX_DRIVE_CURRENT_B: reg_value = {23'h0, drive_b_q};
      `IDX_LIGHT_SLEEP_EXIT: reg_value = {21'h0, light_exit_q};
      `IDX_DEEP_EXIT_PHASE_A: reg_value = {19'h0, deep_phase_a_q};
      `IDX_DEEP_EXIT_TOTAL: reg_value = {19'h0, deep_total_q};
      `IDX_READ_TIMING: reg_value = {25'h0, read_timing_q};
      `IDX_FRAMING_OFFSET: reg_value = {28'h0, framing_q};
      `IDX_READ_DELAY_EXTRA: reg_value = {29'h0, delay_extra_q};
      `IDX_READ_SKIP: reg_value = {29'h0, man_val_q, man_sel_q, auto_skip_q};
      `IDX_CYCLE_TIME: reg_value = {18'h0, cycle_q};
      `IDX_TEST_SCRATCH_B: reg_value = {16'h0, test_b_q};
      `IDX_TEST_SCRATCH_C: reg_value = {16'h0, test_c_q};
      `IDX_TEST_SCRATCH_D: reg_value = {16'h0, test_d_q};
      `IDX_EVENT_CONTROL: reg_value = 32'h0000_0000;
      default: reg_value = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic reg_exists(input logic [7:0] idx);
    reg_exists = (idx >= `IDX_STARTUP_CONTROL && idx <= `IDX_CORE_CONFIG_B) ||
                 (idx >= `IDX_MEMORY_DEVICE_ADDRESS && idx <= `IDX_TEST_SCRATCH_D) ||
                 (idx == `IDX_EVENT_CONTROL);
  endfunction

  assign wr_hit = reg_exists(wr_idx);
  // procedural so the merge tracks register changes, not only the index
  always_comb begin
    wr_old = reg_value(wr_idx);
  end
  assign wr_val = merge(wr_old, wdata_q, wstrb_q);

  logic wr_ev;
  logic ev_fix, ev_set, ev_clr, ev_ser_rst, ev_auto, ev_pair;
  logic chain_reset;
  assign wr_ev = wr_fire && wr_idx == `IDX_EVENT_CONTROL;
  assign ev_fix = wr_ev && wr_val[`EV_DOMAIN_FIX];
  assign ev_set = wr_ev && wr_val[`EV_SET_RESET];
  assign ev_clr = wr_ev && wr_val[`EV_CLEAR_RESET];
  assign ev_ser_rst = wr_ev && wr_val[`EV_SERIAL_RESET];
  assign ev_auto = wr_ev && wr_val[`EV_AUTO_RENEW];
  assign ev_pair = wr_ev && wr_val[`EV_SELF_RENEW_PAIR];

  // set/clear sequence: clear only counts after a set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_seq_q <= RST_IDLE;
    end else if (ev_set) begin
      rst_seq_q <= RST_SET_SEEN;
    end else if (ev_clr) begin
      rst_seq_q <= RST_IDLE;
    end
  end
  assign chain_reset = ev_clr && !ev_set && rst_seq_q == RST_SET_SEEN;

  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = wr_fire && wr_idx == idx;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn || ev_ser_rst || chain_reset) begin
      startup_control_q <= 14'h0000;
      memory_device_address_q <= 5'h00;
      drive_a_q <= 9'h000;
      drive_b_q <= 9'h000;
      man_sel_q <= 1'b0;
      man_val_q <= 1'b0;
    end else begin
      if (wr_to(`IDX_STARTUP_CONTROL)) startup_control_q <= wr_val[13:0];
      if (wr_to(`IDX_MEMORY_DEVICE_ADDRESS)) memory_device_address_q <= wr_val[4:0];
      if (wr_to(`IDX_DRIVE_CURRENT_A)) drive_a_q <= wr_val[8:0];
      if (wr_to(`IDX_DRIVE_CURRENT_B)) drive_b_q <= wr_val[8:0];
      if (wr_to(`IDX_READ_SKIP)) begin
        man_sel_q <= wr_val[`SK_MAN_SEL];
        man_val_q <= wr_val[`SK_MAN_VAL];
      end
    end
  end

  // bank and row: reset on set/clear and serial reset; hardware advance wins over a write
  logic row_step;
  assign row_step = (ev_auto && memory_req_address == memory_device_address_q &&
                     next_bank_q == `ALL_ONES_BANK) ||
                    (ev_pair && self_refresh_active && next_bank_q == `ALL_ONES_BANK);
  always_ff @(posedge aclk) begin
    if (!aresetn || ev_ser_rst || chain_reset) begin
      next_bank_q <= 4'h0;
      next_row_q <= 9'h000;
    end else begin
      if (ev_pair && self_refresh_active) next_bank_q <= next_bank_q + 4'h1;
      else if (wr_to(`IDX_NEXT_BANK)) next_bank_q <= wr_val[3:0];
      if (row_step) next_row_q <= next_row_q + 9'h001;
      else if (wr_to(`IDX_NEXT_ROW)) next_row_q <= wr_val[8:0];
    end
  end

  // timing registers keep undefined-at-reset semantics but start at zero here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      light_exit_q <= 11'h000;
      deep_phase_a_q <= 13'h0000;
      deep_total_q <= 13'h0000;
      read_timing_q <= 7'h00;
      framing_q <= 4'h0;
      delay_extra_q <= 3'h0;
      cycle_q <= 14'h0000;
    end else begin
      if (wr_to(`IDX_LIGHT_SLEEP_EXIT)) light_exit_q <= wr_val[10:0];
      if (wr_to(`IDX_DEEP_EXIT_PHASE_A)) deep_phase_a_q <= wr_val[12:0];
      if (wr_to(`IDX_DEEP_EXIT_TOTAL)) deep_total_q <= wr_val[12:0];
      if (wr_to(`IDX_READ_TIMING)) read_timing_q <= wr_val[6:0];
      if (wr_to(`IDX_READ_DELAY_EXTRA)) delay_extra_q <= wr_val[2:0];
      if (wr_to(`IDX_FRAMING_OFFSET)) framing_q <= wr_val[3:0];
      if (wr_to(`IDX_CYCLE_TIME)) cycle_q <= wr_val[13:0];
    end
  end

  // test scratch: serial reset leaves them alone; software clears test_b
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_a_q <= 16'h0000;
      test_b_q <= 16'h0000;
      test_c_q <= 16'h0000;
      test_d_q <= 16'h0000;
    end else begin
      if (wr_to(`IDX_TEST_SCRATCH_A)) test_a_q <= wr_val[15:0];
      if (wr_to(`IDX_TEST_SCRATCH_B)) test_b_q <= wr_val[15:0];
      if (wr_to(`IDX_TEST_SCRATCH_C)) test_c_q <= wr_val[15:0];
      if (wr_to(`IDX_TEST_SCRATCH_D)) test_d_q <= wr_val[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ev_ser_rst) begin
      auto_skip_q <= 1'b0;
    end else if (ev_fix) begin
      auto_skip_q <= auto_skip_sample;
    end
  end

  // read channel: one read at a time, answered the cycle after acceptance
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_idx;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_idx = word_index(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= reg_value(rd_idx);
      rresp_q <= reg_exists(rd_idx) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign serial_address_match = serial_req_address == startup_control_q[5:0];
  assign memory_address_match = memory_req_address == memory_device_address_q;
  // exit needs address on lane A when selected
  assign exit_address_ok = !startup_control_q[`SC_EXIT_SEL] ||
                           data_lane_a_address == memory_device_address_q;
  assign self_refresh_active =
    (light_sleep_state && startup_control_q[`SC_LIGHT_SR]) ||
    (deep_powerdown_state && startup_control_q[`SC_DEEP_SR]);
  assign low_power_self_refresh = startup_control_q[`SC_LOW_PWR_SR];
  assign framing_select = light_exit_q[`LX_FRAMING_SEL];
  assign effective_skip = man_sel_q ? man_val_q : auto_skip_q;
  assign read_delay_base = read_timing_q[`RT_DELAY_BASE_LSB +: 3];
  assign read_delay_extra = delay_extra_q;
  assign framing_offset = framing_q;
  assign cycle_time_setting = cycle_q;
  assign next_bank_to_renew = next_bank_q;
  assign next_row_to_renew = next_row_q;

  property p_skip_override;
    @(posedge aclk) disable iff (!aresetn)
      man_sel_q |-> effective_skip == man_val_q;
  endproperty
  a_skip_override: assert property (p_skip_override) else $error("skip override lost");

  property p_bank_step;
    @(posedge aclk) disable iff (!aresetn)
      (ev_pair && self_refresh_active && !ev_ser_rst && !chain_reset)
        |=> next_bank_q == $past(next_bank_q) + 4'h1;
  endproperty
  a_bank_step: assert property (p_bank_step) else $error("bank did not advance");

  property p_row_step;
    @(posedge aclk) disable iff (!aresetn)
      (row_step && !ev_ser_rst && !chain_reset) |=> next_row_q == $past(next_row_q) + 9'h001;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row did not advance");

  property p_ro_zero;
    @(posedge aclk) disable iff (!aresetn)
      rvalid_q && rresp_q == 2'h2 |-> rdata_q == 32'h0000_0000;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("unmapped read not zero");

  sequence s_fix;
    ev_fix && !ev_ser_rst;
  endsequence
  property p_fix_capture;
    @(posedge aclk) disable iff (!aresetn)
      s_fix |=> auto_skip_q == $past(auto_skip_sample);
  endproperty
  a_fix_capture: assert property (p_fix_capture) else $error("auto skip not captured");

  property p_sr_gate;
    @(posedge aclk) disable iff (!aresetn)
      self_refresh_active |-> (light_sleep_state || deep_powerdown_state);
  endproperty
  a_sr_gate: assert property (p_sr_gate) else $error("self refresh outside sleep");

  property p_serial_reset;
    @(posedge aclk) disable iff (!aresetn)
      ev_ser_rst |=> next_row_q == 9'h000 && memory_device_address_q == 5'h00;
  endproperty
  a_serial_reset: assert property (p_serial_reset) else $error("reset values missed");

  property p_cycle_store;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_idx == `IDX_CYCLE_TIME) |=> cycle_time_setting == $past(wr_val[13:0]);
  endproperty
  a_cycle_store: assert property (p_cycle_store) else $error("cycle time not stored");

endmodule

// ---- rtl/memory_control_register_map_cfg.svh ----
// register offsets, field positions and timing for the control register bank
// assumes inclusion by the register bank module and the testbench
`ifndef MEMORY_CONTROL_REGISTER_MAP_CFG_SVH
`define MEMORY_CONTROL_REGISTER_MAP_CFG_SVH

// printed offsets are register indices; byte address is four times the index
`define IDX_STARTUP_CONTROL 8'h21
`define IDX_TEST_SCRATCH_A 8'h22
`define IDX_CORE_CONFIG_A 8'h23
`define IDX_CORE_CONFIG_B 8'h24
`define IDX_MEMORY_DEVICE_ADDRESS 8'h40
`define IDX_NEXT_BANK 8'h41
`define IDX_NEXT_ROW 8'h42
`define IDX_DRIVE_CURRENT_A 8'h43
`define IDX_DRIVE_CURRENT_B 8'h44
`define IDX_LIGHT_SLEEP_EXIT 8'h45
`define IDX_DEEP_EXIT_PHASE_A 8'h46
`define IDX_DEEP_EXIT_TOTAL 8'h47
`define IDX_READ_TIMING 8'h48
`define IDX_FRAMING_OFFSET 8'h49
`define IDX_READ_DELAY_EXTRA 8'h4A
`define IDX_READ_SKIP 8'h4B
`define IDX_CYCLE_TIME 8'h4C
`define IDX_TEST_SCRATCH_B 8'h4D
`define IDX_TEST_SCRATCH_C 8'h4E
`define IDX_TEST_SCRATCH_D 8'h4F
`define IDX_EVENT_CONTROL 8'h60

// startup_control fields
`define SC_SDEV_LSB 0
`define SC_EXIT_SEL 6
`define SC_REPEATER 7
`define SC_LIGHT_SR 8
`define SC_DEEP_SR 9
`define SC_LOW_PWR_SR 10
`define SC_TEMP_EN 11
`define SC_TEMP_OUT 12
`define SC_DEV_OFF 13

// light-sleep exit fields
`define LX_PHASE_A_LSB 0
`define LX_TOTAL_LSB 5
`define LX_FRAMING_SEL 10

// read timing fields
`define RT_CAS_LSB 0
`define RT_CLS_LSB 2
`define RT_DELAY_BASE_LSB 4

// skip fields
`define SK_AUTO 0
`define SK_MAN_SEL 1
`define SK_MAN_VAL 2

// event_control pulse bits (write one to fire)
`define EV_DOMAIN_FIX 0
`define EV_SET_RESET 1
`define EV_CLEAR_RESET 2
`define EV_SERIAL_RESET 3
`define EV_AUTO_RENEW 4
`define EV_SELF_RENEW_PAIR 5

`define CYCLE_TIME_UNIT_PS 64
`define ALL_ONES_BANK 4'hF

`endif

// ---- rtl/memory_control_register_map_pkg.sv ----
// types shared by the register bank
// assumes the cfg header supplies all numbers
package memory_control_register_map_pkg;
  typedef enum logic [1:0] {
    RST_IDLE,
    RST_SET_SEEN
  } reset_seq_t;
endpackage
